// >>> hw/asp_defines.vh
// asp_defines.vh: constants of the asynchronous serial port
// assumes a byte-addressed APB slave with 32-bit words
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define ASP_OFS_CTRL   8'h00
`define ASP_OFS_BUF    8'h04
`define ASP_OFS_PWR    8'h08
`define ASP_OFS_BAUD   8'h0c
`define ASP_OFS_RELOAD 8'h10
// ************************************************************
// serial control fields
// ************************************************************
`define ASP_CTL_MODE_HI 7
`define ASP_CTL_MODE_LO 6
`define ASP_CTL_MULTI   5
`define ASP_CTL_RX_EN   4
`define ASP_CTL_TX_NINE 3
`define ASP_CTL_RX_NINE 2
`define ASP_CTL_TX_DONE 1
`define ASP_CTL_RX_DONE 0
// ************************************************************
// power control and baud control fields
// ************************************************************
`define ASP_PWR_DBL    7
`define ASP_PWR_FSEL   6
`define ASP_PWR_SIXCLK 0
`define ASP_BD_RUN     4
`define ASP_BD_TSRC    3
`define ASP_BD_RSRC    2
`define ASP_BD_SPEED   1
// ************************************************************
// reset values and timing counts
// ************************************************************
`define ASP_RST_BYTE   8'h00
`define ASP_OVS_LAST   4'hf
`define ASP_OVS_MID    4'h7
`define ASP_PRE_LAST   3'h5
`define ASP_IDX_STOP8  4'h9
`define ASP_IDX_STOP9  4'ha
`define ASP_MODE0      2'h0
`define ASP_MODE1      2'h1
`define ASP_MODE2      2'h2
`endif

// >>> hw/asp_uart.v
// asp_uart.v: asynchronous serial port, modes 1, 2 and 3, APB slave
// assumes rxd_i and timer1_ovf_i synchronous to clk_i (the oscillator)
`timescale 1ns/1ps
`include "asp_defines.vh"

// Function
// - transmitter and receiver run at the same time on separate pins.
// - 8-bit mode frame is start, eight data, stop: 10 bits.
// - 8-bit mode copies received stop bit into received ninth bit.
// - 9-bit frame is start, eight data LSB first, ninth, stop.
// - received ninth bit stored; transmitted ninth taken from software field.
// - writing the serial buffer starts a transmission in async modes.
// - enabled receiver starts a frame on a falling receive edge.
// - with framing check on, missing stop bit sets framing error.
// - framing error cleared only by software or reset.
// - with framing check on, receive complete raised at stop bit.
// - rx and tx baud sources chosen separately, timer 1 or generator.
// - generator rate: clock times doubling, over 6 unless speed, 32, reload.
// - timer 1 rate: clock times doubling, over 192 and reload.
// - peripheral clock is oscillator halved in 12-clock mode, else equal.
// - mode codes 00 shift, 01 8-bit, 10 9-bit fixed, 11 9-bit variable.
// - mode 2 rate is peripheral clock over 16 or 32.
// - transmit complete set at start of stop bit, held until cleared.
// - generator is 8-bit auto-reload, prescaled by 1 or 6, run bit.
module asp_uart (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // baud source from timer 1
  input  wire        timer1_ovf_i,
  // serial pins
  input  wire        rxd_i,
  output wire        txd_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [7:0] serial_control_reg;
  reg        framing_error_flag;
  reg  [7:0] power_control_reg;
  reg  [7:0] baud_control_reg;
  reg  [7:0] generator_reload_value;
  reg  [7:0] serial_buffer_reg;
  reg        per_half_reg;
  reg  [2:0] pre_reg;
  reg  [7:0] gen_cnt_reg;
  reg        gen_half_reg;
  reg        t1_half_reg;
  reg        m2_half_reg;
  reg        tx_busy_reg;
  reg  [3:0] tx_cnt_reg;
  reg  [3:0] tx_idx_reg;
  reg  [10:0] tx_sh_reg;
  reg        rx_busy_reg;
  reg        rx_prev_reg;
  reg  [3:0] rx_cnt_reg;
  reg  [3:0] rx_idx_reg;
  reg  [7:0] rx_sh_reg;
  reg        rx_nine_reg;
  reg        tx_done_set;
  reg        rx_done_set;
  reg        ferr_set;
  reg        nine_set;
  reg        nine_val;

  wire       mode_select_high = serial_control_reg[`ASP_CTL_MODE_HI];
  wire       mode_select_low  = serial_control_reg[`ASP_CTL_MODE_LO];
  wire [1:0] mode             = {mode_select_high, mode_select_low};
  wire       async_mode       = (mode != `ASP_MODE0);
  wire       eight_bit        = (mode == `ASP_MODE1);
  wire       transmit_ninth_bit = serial_control_reg[`ASP_CTL_TX_NINE];
  wire       rate_doubling_bit  = power_control_reg[`ASP_PWR_DBL];
  wire       framing_select_bit = power_control_reg[`ASP_PWR_FSEL];
  wire       six_clock_core_mode = power_control_reg[`ASP_PWR_SIXCLK];
  wire       generator_run_bit   = baud_control_reg[`ASP_BD_RUN];
  wire       tx_baud_source_sel  = baud_control_reg[`ASP_BD_TSRC];
  wire       rx_baud_source_sel  = baud_control_reg[`ASP_BD_RSRC];
  wire       generator_speed_bit = baud_control_reg[`ASP_BD_SPEED];

  // register decode, used by both write and read paths
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `ASP_OFS_CTRL:   reg_sel = 3'h1;
        `ASP_OFS_BUF:    reg_sel = 3'h2;
        `ASP_OFS_PWR:    reg_sel = 3'h3;
        `ASP_OFS_BAUD:   reg_sel = 3'h4;
        `ASP_OFS_RELOAD: reg_sel = 3'h5;
        default:         reg_sel = 3'h0;
      endcase
    end
  endfunction

  wire [2:0] sel    = reg_sel(paddr_i);
  wire       wr_en  = psel_i & penable_i & pwrite_i;
  wire       wr_ctl = wr_en & (sel == 3'h1);
  wire       wr_buf = wr_en & (sel == 3'h2);

  // ************************************************************
  // apb handshake: zero wait states, error on unmapped address
  // ************************************************************
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & (sel == 3'h0);

  // read data captured in the setup cycle, stable in the access
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      case (sel)
        3'h1: prdata_o <= {24'h000000, (framing_select_bit ? framing_error_flag : mode_select_high),
                           serial_control_reg[6:0]};
        3'h2: prdata_o <= {24'h000000, serial_buffer_reg};
        3'h3: prdata_o <= {24'h000000, power_control_reg};
        3'h4: prdata_o <= {27'h0000000, baud_control_reg[4:0]};
        3'h5: prdata_o <= {24'h000000, generator_reload_value};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // software registers and hardware flags (set beats clear)
  // ************************************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_control_reg     <= `ASP_RST_BYTE;
      framing_error_flag     <= 1'b0;
      power_control_reg      <= `ASP_RST_BYTE;
      baud_control_reg       <= `ASP_RST_BYTE;
      generator_reload_value <= `ASP_RST_BYTE;
    end else begin
      if (wr_ctl) begin
        // bit 7 is the mode bit only while framing select is clear
        if (!framing_select_bit)
          serial_control_reg[7] <= pwdata_i[7];
        serial_control_reg[6:3] <= pwdata_i[6:3];
      end
      if (nine_set)
        serial_control_reg[`ASP_CTL_RX_NINE] <= nine_val;
      else if (wr_ctl)
        serial_control_reg[`ASP_CTL_RX_NINE] <= pwdata_i[`ASP_CTL_RX_NINE];
      serial_control_reg[`ASP_CTL_TX_DONE] <= tx_done_set |
        (wr_ctl ? pwdata_i[`ASP_CTL_TX_DONE] : serial_control_reg[`ASP_CTL_TX_DONE]);
      serial_control_reg[`ASP_CTL_RX_DONE] <= rx_done_set |
        (wr_ctl ? pwdata_i[`ASP_CTL_RX_DONE] : serial_control_reg[`ASP_CTL_RX_DONE]);
      // only set by hardware, only cleared by a software write or reset
      framing_error_flag <= ferr_set |
        ((wr_ctl & framing_select_bit) ? (pwdata_i[7] & framing_error_flag) : framing_error_flag);
      if (wr_en & (sel == 3'h3))
        power_control_reg <= pwdata_i[7:0];
      if (wr_en & (sel == 3'h4))
        baud_control_reg <= {3'h0, pwdata_i[4:0]};
      if (wr_en & (sel == 3'h5))
        generator_reload_value <= pwdata_i[7:0];
    end
  end

  // ************************************************************
  // peripheral clock enable and baud generators
  // ************************************************************
  wire per_en  = six_clock_core_mode | per_half_reg;
  wire pre_hit = (pre_reg == `ASP_PRE_LAST);
  wire gen_tick = generator_run_bit & per_en & (generator_speed_bit | pre_hit);
  wire gen_ovf  = gen_tick & (gen_cnt_reg == 8'hff);
  // doubling bit skips the halving stage: 16 samples per bit either way
  wire gen_s  = gen_ovf & (rate_doubling_bit | gen_half_reg);
  wire t1_s   = timer1_ovf_i & (rate_doubling_bit | t1_half_reg);
  wire m2_s   = per_en & (rate_doubling_bit | m2_half_reg);
  wire tx_s   = (mode == `ASP_MODE2) ? m2_s : (tx_baud_source_sel ? gen_s : t1_s);
  wire rx_s   = (mode == `ASP_MODE2) ? m2_s : (rx_baud_source_sel ? gen_s : t1_s);

  // prescalers, auto-reload counter and halving toggles
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_half_reg <= 1'b0;
      pre_reg      <= 3'h0;
      gen_cnt_reg  <= 8'h00;
      gen_half_reg <= 1'b0;
      t1_half_reg  <= 1'b0;
      m2_half_reg  <= 1'b0;
    end else begin
      per_half_reg <= ~per_half_reg;
      if (per_en)
        pre_reg <= pre_hit ? 3'h0 : pre_reg + 3'h1;
      if (gen_tick)
        gen_cnt_reg <= gen_ovf ? generator_reload_value : gen_cnt_reg + 8'h01;
      if (gen_ovf)
        gen_half_reg <= ~gen_half_reg;
      if (timer1_ovf_i)
        t1_half_reg <= ~t1_half_reg;
      if (per_en)
        m2_half_reg <= ~m2_half_reg;
    end
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  wire [3:0] tx_last = eight_bit ? `ASP_IDX_STOP8 : `ASP_IDX_STOP9;
  // own shifter and counters, independent of the receiver
  assign txd_o = tx_busy_reg ? tx_sh_reg[0] : 1'b1;

  // shifts one bit every sixteen samples
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg  <= 4'h0;
      tx_idx_reg  <= 4'h0;
      tx_sh_reg   <= 11'h7ff;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (!tx_busy_reg) begin
        if (wr_buf & async_mode) begin
          tx_busy_reg <= 1'b1;
          tx_cnt_reg  <= 4'h0;
          tx_idx_reg  <= 4'h0;
          tx_sh_reg   <= {1'b1, (eight_bit | transmit_ninth_bit), pwdata_i[7:0], 1'b0};
        end
      end else if (tx_s) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
        if (tx_cnt_reg == `ASP_OVS_LAST) begin
          tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
          tx_idx_reg <= tx_idx_reg + 4'h1;
          if (tx_idx_reg + 4'h1 == tx_last)
            tx_done_set <= 1'b1;
          if (tx_idx_reg == tx_last)
            tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  wire       rx_mid    = rx_s & (rx_cnt_reg == `ASP_OVS_MID);
  wire [3:0] rx_stop   = eight_bit ? `ASP_IDX_STOP8 : `ASP_IDX_STOP9;
  wire       done_ninth = ~eight_bit & ~framing_select_bit;
  wire       ren       = serial_control_reg[`ASP_CTL_RX_EN];

  // falling-edge start, mid-bit sampling, completion and checks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_busy_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      rx_cnt_reg  <= 4'h0;
      rx_idx_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      rx_nine_reg <= 1'b0;
      serial_buffer_reg <= `ASP_RST_BYTE;
      rx_done_set <= 1'b0;
      ferr_set    <= 1'b0;
      nine_set    <= 1'b0;
      nine_val    <= 1'b0;
    end else begin
      rx_prev_reg <= rxd_i;
      rx_done_set <= 1'b0;
      ferr_set    <= 1'b0;
      nine_set    <= 1'b0;
      if (!rx_busy_reg) begin
        if (ren & async_mode & rx_prev_reg & ~rxd_i) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= 4'h0;
          rx_idx_reg  <= 4'h0;
        end
      end else if (!ren) begin
        rx_busy_reg <= 1'b0;
      end else if (rx_s) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        if (rx_mid) begin
          rx_idx_reg <= rx_idx_reg + 4'h1;
          if (rx_idx_reg == 4'h0) begin
            if (rxd_i)
              rx_busy_reg <= 1'b0;
          end else if (rx_idx_reg < `ASP_IDX_STOP8) begin
            rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]};
          end else if (rx_idx_reg == `ASP_IDX_STOP8 && !eight_bit) begin
            rx_nine_reg <= rxd_i;
            if (done_ninth) begin
              serial_buffer_reg <= rx_sh_reg;
              rx_done_set <= 1'b1;
              nine_set    <= 1'b1;
              nine_val    <= rxd_i;
            end
          end
          if (rx_idx_reg == rx_stop) begin
            rx_busy_reg <= 1'b0;
            ferr_set <= framing_select_bit & ~rxd_i;
            if (!done_ninth) begin
              serial_buffer_reg <= rx_sh_reg;
              rx_done_set <= 1'b1;
              nine_set    <= 1'b1;
              nine_val    <= eight_bit ? rxd_i : rx_nine_reg;
            end
          end
        end
      end
    end
  end

endmodule // asp_uart

// >>> verif/asp_uart_chk.sv
// asp_uart_chk.sv: port assertions for asp_uart
// assumes bind onto asp_uart, one clock domain
`timescale 1ns/1ps
module asp_chk (
  // clock, reset
  input wire        clk_i,
  input wire        rst_n_i,
  // apb
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  // serial
  input wire        txd_o
);
  // ****
  // helpers
  // ****
  reg  [1:0] age_reg;
  wire       hit = paddr_i[7:2] < 6'h05 && paddr_i[1:0] == 2'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_set; psel_i && !penable_i && !pwrite_i; endsequence
  sequence acc; psel_i && penable_i; endsequence
  // cycles since reset, saturating
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  end
  chk_ready_high: assert property (acc |-> pready_o) else $error("ready low");
  chk_err_unmap: assert property (acc ##0 !hit |-> pslverr_o) else $error("no slverr");
  chk_err_map: assert property (acc ##0 hit |-> !pslverr_o) else $error("bad slverr");
  chk_rd_unmap: assert property (rd_set ##0 !hit |=> prdata_o == 32'h0) else $error("unmapped data");
  chk_rd_upper: assert property (prdata_o[31:8] == 24'h0) else $error("upper bits set");
  chk_idle_reset: assert property (age_reg < 2'h2 |-> txd_o) else $error("txd not idle");
  chk_low_len: assert property ($fell(txd_o) |-> !txd_o [*8]) else $error("short low bit");
  chk_high_len: assert property ($rose(txd_o) |-> txd_o [*8]) else $error("short high bit");
endmodule // asp_chk

// >>> verif/asp_term.sv
// asp_term.sv: far-end serial terminal model
// assumes its receive line has a pull-up, so it idles high
`timescale 1ns/1ps
module asp_term (
  // clock
  input  wire clk_i,
  // serial
  input  wire txd_i,
  output reg  rxd_o
);
  integer    bit_cyc = 16;
  integer    nbits   = 10;
  integer    got_cnt = 0;
  integer    n       = 0;
  integer    cnt     = 0;
  reg        prev    = 1'b1;
  reg [10:0] sh      = 11'h0;
  reg [10:0] frame   = 11'h0;
  initial rxd_o = 1'b1;
  // sends a frame lsb first, start bit in f[0]
  task send(input [10:0] f, input integer nb, input integer bc);
    integer i;
    for (i = 0; i < nb; i = i + 1) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (bc - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  // mid-bit sampler of the device's transmit line
  always @(posedge clk_i) begin
    prev <= txd_i;
    if (n == 0) begin
      if (prev && !txd_i) begin
        n   <= 1;
        cnt <= bit_cyc / 2;
      end
    end else if (cnt == 0) begin
      sh  <= {txd_i, sh[10:1]};
      cnt <= bit_cyc - 1;
      n   <= (n == nbits) ? 0 : n + 1;
      if (n == nbits) begin
        frame   <= {txd_i, sh[10:1]} >> (11 - nbits);
        got_cnt <= got_cnt + 1;
      end
    end else
      cnt <= cnt - 1;
  end
endmodule // asp_term

// >>> verif/tb.sv
// tb.sv: self-checking bench for the serial port
// assumes asp_uart, asp_term and asp_chk are compiled first
`timescale 1ns/1ps
`include "asp_defines.vh"
`define CHK(a, e) begin check_count = check_count + 1; if ((a) !== (e)) begin \
  miscompares = miscompares + 1; $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  reg         clk_i        = 1'b0;
  reg         rst_n_i      = 1'b0;
  reg         psel_i       = 1'b0;
  reg         penable_i    = 1'b0;
  reg         pwrite_i     = 1'b0;
  reg  [7:0]  paddr_i      = 8'h00;
  reg  [31:0] pwdata_i     = 32'h0;
  reg         timer1_ovf_i = 1'b0;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, rxd_i, txd_o;
  reg  [31:0] rd;
  reg         err;
  integer     miscompares  = 0;
  integer     check_count  = 0;
  integer     i;
  asp_uart dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .timer1_ovf_i(timer1_ovf_i), .rxd_i(rxd_i), .txd_o(txd_o));
  asp_term term_u (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
  initial forever #5 clk_i = ~clk_i;
  // timer 1 overflow pulse every second cycle
  always @(posedge clk_i) timer1_ovf_i <= ~timer1_ovf_i;
  // ****
  // bus and helper tasks
  // ****
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k = k + 1;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 50) miscompares = miscompares + 1;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // one transfer each way, then frame, buffer and control checks
  task duplex(input [7:0] ctl, bd, txv, rxv, input t9, r9, stp, input integer nb, tc, input [7:0] ectl);
    integer k, c0;
    reg [10:0] f, e;
    f = (nb == 10) ? {1'b0, stp, rxv, 1'b0} : {stp, r9, rxv, 1'b0};
    e = (nb == 10) ? {2'b01, txv, 1'b0} : {1'b1, t9, txv, 1'b0};
    apb(1'b1, `ASP_OFS_CTRL, {24'h0, ctl});
    apb(1'b1, `ASP_OFS_BAUD, {24'h0, bd});
    term_u.bit_cyc = tc;
    term_u.nbits = nb;
    c0 = term_u.got_cnt;
    k = 0;
    fork
      apb(1'b1, `ASP_OFS_BUF, {24'h0, txv});
      term_u.send(f, nb, 16);
    join
    while (term_u.got_cnt == c0 && k < 2000) begin
      @(posedge clk_i);
      k = k + 1;
    end
    repeat (tc) @(posedge clk_i);
    `CHK(term_u.frame, e)
    rchk(`ASP_OFS_BUF, {24'h0, rxv});
    rchk(`ASP_OFS_CTRL, {24'h0, ectl});
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    for (i = 0; i < 5; i = i + 1)
      rchk(8'(i * 4), 32'h0);
    apb(1'b1, `ASP_OFS_RELOAD, 32'hff);
    rchk(`ASP_OFS_RELOAD, 32'hff);
    apb(1'b1, `ASP_OFS_BAUD, 32'h1e);
    rchk(`ASP_OFS_BAUD, 32'h1e);
    apb(1'b1, `ASP_OFS_PWR, 32'h81);
    apb(1'b1, 8'h14, 32'h5a);
    `CHK(err, 1'b1)
    rchk(8'h14, 32'h0);
    // generator starts from zero: let it reach its first reload
    repeat (300) @(posedge clk_i);
  endtask
  task t_mode1;
    duplex(8'h50, 8'h1e, 8'ha5, 8'h3c, 1'b0, 1'b0, 1'b1, 10, 16, 8'h57);
  endtask
  task t_mode3;
    duplex(8'hd8, 8'h16, 8'h69, 8'h96, 1'b1, 1'b0, 1'b1, 11, 32, 8'hdb);
  endtask
  task t_mode2;
    duplex(8'h98, 8'h1e, 8'h5a, 8'h0f, 1'b1, 1'b1, 1'b1, 11, 16, 8'h9f);
  endtask
  task t_frame;
    apb(1'b1, `ASP_OFS_CTRL, 32'h50);
    apb(1'b1, `ASP_OFS_PWR, 32'hc1);
    duplex(8'h50, 8'h1e, 8'h11, 8'he7, 1'b0, 1'b0, 1'b0, 10, 16, 8'hd3);
    duplex(8'hd0, 8'h1e, 8'h22, 8'h81, 1'b0, 1'b0, 1'b1, 10, 16, 8'hd7);
    apb(1'b1, `ASP_OFS_CTRL, 32'h50);
    rchk(`ASP_OFS_CTRL, 32'h50);
  endtask
  // 9-bit receive: completion flag at the ninth bit, or at stop with framing check
  task rx_at(input [7:0] pw, input stp, input [7:0] emid);
    apb(1'b1, `ASP_OFS_PWR, 32'h81);
    apb(1'b1, `ASP_OFS_CTRL, 32'hd0);
    apb(1'b1, `ASP_OFS_PWR, {24'h0, pw});
    fork
      term_u.send({stp, 1'b1, 8'hc3, 1'b0}, 11, 16);
      begin
        repeat (160) @(posedge clk_i);
        rchk(`ASP_OFS_CTRL, {24'h0, emid});
      end
    join
    repeat (16) @(posedge clk_i);
    rchk(`ASP_OFS_BUF, 32'hc3);
    rchk(`ASP_OFS_CTRL, 32'hd5);
  endtask
  task results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_mode1;
    t_mode3;
    t_mode2;
    t_frame;
    rx_at(8'h81, 1'b1, 8'hd5);
    rx_at(8'hc1, 1'b0, 8'h50);
    results;
  end
  // watchdog
  initial begin
    #200000;
    miscompares = miscompares + 1;
    results;
  end
endmodule // tb
bind asp_uart asp_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .txd_o(txd_o));
